// *** include/ufmc_pkg.sv ***
package ufmc_pkg;

    // ------------------------------------------------------------------
    // Register addresses (3-bit host address)
    // ------------------------------------------------------------------
    localparam logic [2:0] UFMC_ADDR_DATA   = 3'h0;
    localparam logic [2:0] UFMC_ADDR_DIVHI  = 3'h1;
    localparam logic [2:0] UFMC_ADDR_STATUS = 3'h2;
    localparam logic [2:0] UFMC_ADDR_LINE   = 3'h3;
    localparam logic [2:0] UFMC_ADDR_MODEM  = 3'h4;
    localparam logic [2:0] UFMC_ADDR_DIVFR  = 3'h2;

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int UFMC_FC_EN     = 0;
    localparam int UFMC_FC_RXRST  = 1;
    localparam int UFMC_FC_TXRST  = 2;
    localparam int UFMC_FC_WAKE   = 3;
    localparam int UFMC_FC_TXTRG  = 4;
    localparam int UFMC_FC_RXTRG  = 6;
    localparam int UFMC_LC_STOP   = 2;
    localparam int UFMC_LC_PAREN  = 3;
    localparam int UFMC_LC_EVEN   = 4;
    localparam int UFMC_LC_FORCE  = 5;
    localparam int UFMC_LC_BREAK  = 6;
    localparam int UFMC_LC_DLAB   = 7;
    localparam int UFMC_MC_DTR    = 0;
    localparam int UFMC_MC_RTS    = 1;
    localparam int UFMC_MC_OUT1   = 2;
    localparam int UFMC_MC_OUT2   = 3;
    localparam int UFMC_MC_LOOP   = 4;
    localparam int UFMC_MC_ANY    = 5;
    localparam int UFMC_IS_FLOW   = 5;
    localparam int UFMC_EF_ENH    = 4;

    // ------------------------------------------------------------------
    // Reset values and sizes
    // ------------------------------------------------------------------
    localparam logic [7:0] UFMC_LINE_RST  = 8'h00;
    localparam logic [7:0] UFMC_MODEM_RST = 8'h00;
    localparam logic [7:0] UFMC_DIV_RST   = 8'h00;
    localparam int         UFMC_FIFO_W    = 8;
    localparam int         UFMC_FIFO_D    = 32;
    localparam int         UFMC_CNT_W     = 6;
    localparam logic [UFMC_CNT_W-1:0] UFMC_TRG_1  = 6'h01;
    localparam logic [UFMC_CNT_W-1:0] UFMC_TRG_4  = 6'h04;
    localparam logic [UFMC_CNT_W-1:0] UFMC_TRG_8  = 6'h08;
    localparam logic [UFMC_CNT_W-1:0] UFMC_TRG_14 = 6'h0E;

    typedef struct packed {
        logic [1:0] word_len;
        logic       two_stop;
        logic       par_en;
        logic       par_even;
        logic       par_force;
        logic       brk;
    } ufmc_format_type;

    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [2:0] addr;
        logic [7:0] wdata;
    } ufmc_host_type;

    function automatic logic [UFMC_CNT_W-1:0] ufmc_trig(input logic [1:0] code);
        unique case (code)
            2'b00: ufmc_trig = UFMC_TRG_1;
            2'b01: ufmc_trig = UFMC_TRG_4;
            2'b10: ufmc_trig = UFMC_TRG_8;
            2'b11: ufmc_trig = UFMC_TRG_14;
        endcase
    endfunction : ufmc_trig

endpackage : ufmc_pkg

// *** hdl/ufmc_fifo.sv ***
`timescale 1ns/1ps
module ufmc_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 32,
    parameter int CW    = 6
) (
    input  wire logic             sys_clk,
    input  wire logic             arst_n,
    input  wire logic             flush,
    input  wire logic [WIDTH-1:0] in_data,
    input  wire logic             in_valid,
    output logic                  in_ready,
    output logic      [WIDTH-1:0] out_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [CW-1:0]    level
);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [CW-2:0]    wr_q;
    logic [CW-2:0]    rd_q;
    logic [CW-1:0]    cnt_q;
    logic             push;
    logic             pop;

    assign in_ready  = (cnt_q != CW'(DEPTH));
    assign out_valid = (cnt_q != '0);
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;
    assign out_data  = mem[rd_q];
    assign level     = cnt_q;

    // Flush only clears pointers and count; stored words stay but are unreachable
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            wr_q  <= '0;
            rd_q  <= '0;
            cnt_q <= '0;
        end else if (flush) begin
            wr_q  <= '0;
            rd_q  <= '0;
            cnt_q <= '0;
        end else begin
            if (push) begin
                wr_q <= wr_q + 1'b1;
            end
            if (pop) begin
                rd_q <= rd_q + 1'b1;
            end
            cnt_q <= cnt_q + CW'(push) - CW'(pop);
        end
    end

    always_ff @(posedge sys_clk) begin
        if (push) begin
            mem[wr_q] <= in_data;
        end
    end
endmodule : ufmc_fifo

// *** hdl/ufmc_core.sv ***
`timescale 1ns/1ps
// ----------------------------------------------------------------------
// ----------------------------------------------------------------------
module ufmc_core
    import ufmc_pkg::*;
(
    input  wire logic        sys_clk,
    input  wire logic        arst_n,
    input  ufmc_host_type    host,
    output logic      [7:0]  rdata,
    input  wire logic        enhanced_feature_register_en,
    input  wire logic        int_req,
    output logic             int_out,
    output logic             int_oe,
    input  wire logic [7:0]  tx_in_data,
    output logic             tx_in_ready,
    output logic      [7:0]  tx_char,
    output logic             tx_char_valid,
    input  wire logic        tx_char_ready,
    input  wire logic [7:0]  rx_char,
    input  wire logic        rx_char_valid,
    input  wire logic        rx_char_is_flow,
    output logic      [7:0]  rx_out_data,
    output logic             rx_out_valid,
    input  wire logic        rx_out_ready,
    output ufmc_format_type  fmt,
    output logic             par_value,
    output logic             par_forced,
    output logic             half_stop,
    output logic             tx_line_low,
    output logic             dtr_n,
    output logic             rts_n,
    input  wire logic        cts_n_pin,
    input  wire logic        ring_indicator_in_n,
    output logic             ring_in_looped_n,
    output logic             user_output_one_n,
    output logic             user_output_two_n,
    output logic             loopback,
    output logic             tx_resume,
    output logic             wake_int_en,
    output logic             tx_int,
    output logic             rx_int,
    output logic      [7:0]  div_low,
    output logic      [7:0]  divisor_high,
    output logic      [7:0]  divisor_fraction
);
    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    logic [7:0]            line_q;
    logic [7:0]            modem_q;
    logic                  fifo_en_q;
    logic                  wake_q;
    logic [1:0]            trig_q;
    logic [7:0]            dll_q;
    logic [7:0]            dlm_q;
    logic [7:0]            dld_q;
    logic                  rx_flush_q;
    logic                  tx_flush_q;
    logic                  cts_s1_q;
    logic                  cts_s2_q;
    logic                  ri_s1_q;
    logic                  ri_s2_q;
    logic                  cts_prev_q;
    logic                  rts_prev_q;
    logic                  flow_q;
    logic                  reload_short_q;
    logic                  tx_empty_prev_q;
    logic                  tx_empty_int_q;
    logic [UFMC_CNT_W-1:0] tx_level;
    logic [UFMC_CNT_W-1:0] rx_level;
    logic [UFMC_CNT_W-1:0] trig_lvl;
    logic                  wr_fc;
    logic                  wr_line;
    logic                  wr_modem;
    logic                  dlab;
    logic                  cts_eff;
    logic                  rts_eff;
    logic                  rx_push;

    assign dlab     = line_q[UFMC_LC_DLAB];
    assign wr_fc    = host.wr && (host.addr == UFMC_ADDR_STATUS) && !dlab;
    assign wr_line  = host.wr && (host.addr == UFMC_ADDR_LINE);
    assign wr_modem = host.wr && (host.addr == UFMC_ADDR_MODEM);
    assign trig_lvl = ufmc_trig(trig_q);

    // ------------------------------------------------------------------
    // FIFO control
    // ------------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            fifo_en_q <= 1'b0;
        end else if (wr_fc) begin
            fifo_en_q <= host.wdata[UFMC_FC_EN];
        end
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            rx_flush_q <= 1'b0;
            tx_flush_q <= 1'b0;
        end else begin
            rx_flush_q <= wr_fc && host.wdata[UFMC_FC_EN] && host.wdata[UFMC_FC_RXRST];
            tx_flush_q <= wr_fc && host.wdata[UFMC_FC_EN] && host.wdata[UFMC_FC_TXRST];
        end
    end

    // One shared field holds the trigger, so the last write wins for both sides
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            trig_q <= 2'b00;
            wake_q <= 1'b0;
        end else if (wr_fc && host.wdata[UFMC_FC_EN]) begin
            trig_q <= host.wdata[UFMC_FC_RXTRG +: 2];
            if (enhanced_feature_register_en) begin
                wake_q <= host.wdata[UFMC_FC_WAKE];
                if (host.wdata[UFMC_FC_TXTRG +: 2] != 2'b00) begin
                    trig_q <= host.wdata[UFMC_FC_TXTRG +: 2];
                end
            end
        end
    end

    assign wake_int_en = wake_q;

    // ------------------------------------------------------------------
    // Line, modem and divisor registers
    // ------------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            line_q <= UFMC_LINE_RST;
        end else if (wr_line) begin
            line_q <= host.wdata;
        end
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            modem_q <= UFMC_MODEM_RST;
        end else if (wr_modem) begin
            modem_q <= host.wdata;
            if (!enhanced_feature_register_en) begin
                modem_q[UFMC_MC_ANY] <= modem_q[UFMC_MC_ANY];
            end
        end
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            dll_q <= UFMC_DIV_RST;
            dlm_q <= UFMC_DIV_RST;
            dld_q <= UFMC_DIV_RST;
        end else if (host.wr && dlab) begin
            if (host.addr == UFMC_ADDR_DATA) begin
                dll_q <= host.wdata;
            end
            if (host.addr == UFMC_ADDR_DIVHI) begin
                dlm_q <= host.wdata;
            end
            if (host.addr == UFMC_ADDR_DIVFR) begin
                dld_q <= host.wdata;
            end
        end
    end

    assign div_low          = dll_q;
    assign divisor_high     = dlm_q;
    assign divisor_fraction = dld_q;

    // ------------------------------------------------------------------
    // Character format
    // ------------------------------------------------------------------
    assign fmt.word_len  = line_q[1:0];
    assign fmt.two_stop  = line_q[UFMC_LC_STOP];
    assign half_stop     = line_q[UFMC_LC_STOP] && (line_q[1:0] == 2'b00);
    assign fmt.par_en    = line_q[UFMC_LC_PAREN];
    assign fmt.par_even  = line_q[UFMC_LC_EVEN];
    assign fmt.par_force = line_q[UFMC_LC_FORCE];
    assign fmt.brk       = line_q[UFMC_LC_BREAK];
    assign par_forced    = line_q[UFMC_LC_PAREN] && line_q[UFMC_LC_FORCE];
    assign par_value     = !line_q[UFMC_LC_EVEN];
    assign tx_line_low   = line_q[UFMC_LC_BREAK];

    // ------------------------------------------------------------------
    // Modem outputs and loopback
    // ------------------------------------------------------------------
    assign loopback          = modem_q[UFMC_MC_LOOP];
    assign dtr_n             = loopback ? 1'b1 : !modem_q[UFMC_MC_DTR];
    assign rts_n             = loopback ? 1'b1 : !modem_q[UFMC_MC_RTS];
    assign user_output_one_n = !modem_q[UFMC_MC_OUT1];
    assign ring_in_looped_n  = loopback ? !modem_q[UFMC_MC_OUT1] : ri_s2_q;
    assign user_output_two_n = !modem_q[UFMC_MC_OUT2];
    assign int_oe            = modem_q[UFMC_MC_OUT2] && !loopback;
    assign int_out           = int_req;

    // Pins pass two flops before any logic looks at them; reset to idle high
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            cts_s1_q <= 1'b1;
            cts_s2_q <= 1'b1;
            ri_s1_q  <= 1'b1;
            ri_s2_q  <= 1'b1;
        end else begin
            cts_s1_q <= cts_n_pin;
            cts_s2_q <= cts_s1_q;
            ri_s1_q  <= ring_indicator_in_n;
            ri_s2_q  <= ri_s1_q;
        end
    end

    assign cts_eff = loopback ? !modem_q[UFMC_MC_RTS] : cts_s2_q;
    assign rts_eff = !modem_q[UFMC_MC_RTS];

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            cts_prev_q <= 1'b1;
            rts_prev_q <= 1'b1;
        end else begin
            cts_prev_q <= cts_eff;
            rts_prev_q <= rts_eff;
        end
    end

    // Set wins over clear on a status read in the same cycle
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            flow_q <= 1'b0;
        end else if (enhanced_feature_register_en &&
                     ((cts_eff && !cts_prev_q) || (rts_eff && !rts_prev_q))) begin
            flow_q <= 1'b1;
        end else if (host.rd && (host.addr == UFMC_ADDR_STATUS) && !dlab) begin
            flow_q <= 1'b0;
        end
    end

    assign rx_push   = rx_char_valid && !(enhanced_feature_register_en && rx_char_is_flow);
    assign tx_resume = enhanced_feature_register_en && modem_q[UFMC_MC_ANY] && rx_char_valid;

    // ------------------------------------------------------------------
    // FIFOs
    // ------------------------------------------------------------------
    ufmc_fifo #(.WIDTH(UFMC_FIFO_W), .DEPTH(UFMC_FIFO_D), .CW(UFMC_CNT_W)) u_tx_fifo (
        .sys_clk   (sys_clk),
        .arst_n    (arst_n),
        .flush     (tx_flush_q),
        .in_data   (tx_in_data),
        .in_valid  (host.wr && (host.addr == UFMC_ADDR_DATA) && !dlab),
        .in_ready  (tx_in_ready),
        .out_data  (tx_char),
        .out_valid (tx_char_valid),
        .out_ready (tx_char_ready),
        .level     (tx_level)
    );

    ufmc_fifo #(.WIDTH(UFMC_FIFO_W), .DEPTH(UFMC_FIFO_D), .CW(UFMC_CNT_W)) u_rx_fifo (
        .sys_clk   (sys_clk),
        .arst_n    (arst_n),
        .flush     (rx_flush_q),
        .in_data   (rx_char),
        .in_valid  (rx_push),
        .in_ready  (),
        .out_data  (rx_out_data),
        .out_valid (rx_out_valid),
        .out_ready (rx_out_ready),
        .level     (rx_level)
    );

    // Remember whether the last reload stayed at or under the trigger
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            reload_short_q  <= 1'b1;
            tx_empty_prev_q <= 1'b1;
            tx_empty_int_q  <= 1'b0;
        end else begin
            tx_empty_prev_q <= (tx_level == '0);
            if (tx_level > trig_lvl) begin
                reload_short_q <= 1'b0;
            end else if (tx_level == '0) begin
                reload_short_q <= 1'b1;
            end
            tx_empty_int_q <= (tx_level == '0) && !tx_empty_prev_q && reload_short_q;
        end
    end

    assign tx_int = fifo_en_q && ((tx_level < trig_lvl) || tx_empty_int_q);
    assign rx_int = fifo_en_q && (rx_level >= trig_lvl);

    // ------------------------------------------------------------------
    // Read mux
    // ------------------------------------------------------------------
    always_comb begin
        rdata = 8'h00;
        unique case (host.addr)
            UFMC_ADDR_DATA:   rdata = dlab ? dll_q : rx_out_data;
            UFMC_ADDR_DIVHI:  rdata = dlab ? dlm_q : 8'h00;
            UFMC_ADDR_STATUS: rdata = dlab ? dld_q :
                              {{2{fifo_en_q}}, flow_q && enhanced_feature_register_en, 5'h01};
            UFMC_ADDR_LINE:   rdata = line_q;
            UFMC_ADDR_MODEM:  rdata = modem_q;
            default:          rdata = 8'h00;
        endcase
    end
endmodule : ufmc_core

// *** sim/ufmc_chk.sv ***
`timescale 1ns/1ps
module ufmc_chk
    import ufmc_pkg::*;
(
    input logic            sys_clk,
    input logic            arst_n,
    input ufmc_host_type   host,
    input logic            enhanced_feature_register_en,
    input logic            rx_char_valid,
    input logic            ring_indicator_in_n,
    input ufmc_format_type fmt,
    input logic            par_value,
    input logic            par_forced,
    input logic            half_stop,
    input logic            tx_line_low,
    input logic            dtr_n,
    input logic            rts_n,
    input logic            ring_in_looped_n,
    input logic            user_output_one_n,
    input logic            user_output_two_n,
    input logic            loopback,
    input logic            tx_resume
);
    // ------
    // Write-to-pin relations and the resume cause
    // ------
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!arst_n);
    sequence s_mwr;
        host.wr && host.addr == UFMC_ADDR_MODEM;
    endsequence
    sequence s_lwr;
        host.wr && host.addr == UFMC_ADDR_LINE;
    endsequence
    property p_dtr;
        s_mwr |=> dtr_n == (!$past(host.wdata[0]) || $past(host.wdata[4]));
    endproperty
    a_dtr: assert property (p_dtr) else $error("dtr_n wrong after modem write");
    property p_rts;
        s_mwr |=> rts_n == (!$past(host.wdata[1]) || $past(host.wdata[4]));
    endproperty
    a_rts: assert property (p_rts) else $error("rts_n wrong after modem write");
    property p_loop;
        s_mwr |=> loopback == $past(host.wdata[4]) && user_output_two_n == !$past(host.wdata[3]);
    endproperty
    a_loop: assert property (p_loop) else $error("loopback or user output two wrong");
    property p_ring;
        s_mwr ##1 loopback |-> ring_in_looped_n == !$past(host.wdata[2]) &&
                               user_output_one_n == !$past(host.wdata[2]);
    endproperty
    a_ring: assert property (p_ring) else $error("looped ring indicator wrong");
    property p_brk;
        s_lwr |=> tx_line_low == $past(host.wdata[6]);
    endproperty
    a_brk: assert property (p_brk) else $error("break level wrong");
    property p_wlen;
        s_lwr |=> fmt.word_len == $past(host.wdata[1:0]) && fmt.par_en == $past(host.wdata[3]);
    endproperty
    a_wlen: assert property (p_wlen) else $error("format fields wrong");
    property p_half;
        s_lwr |=> half_stop == ($past(host.wdata[2]) && $past(host.wdata[1:0]) == 2'b00);
    endproperty
    a_half: assert property (p_half) else $error("half stop wrong");
    // Forced parity level is the inverse of the even select
    property p_force;
        s_lwr |=> par_forced == ($past(host.wdata[3]) && $past(host.wdata[5])) &&
                  (!par_forced || par_value == !$past(host.wdata[4]));
    endproperty
    a_force: assert property (p_force) else $error("forced parity wrong");
    property p_res;
        tx_resume |-> rx_char_valid && enhanced_feature_register_en;
    endproperty
    a_res: assert property (p_res) else $error("resume without cause");
endmodule : ufmc_chk

// *** sim/ufmc_line_model.sv ***
`timescale 1ns/1ps
module ufmc_line_model (
    input  logic       sys_clk,
    input  logic       drain_en,
    input  logic [7:0] tx_char,
    input  logic       tx_char_valid,
    output logic       tx_char_ready,
    output logic [7:0] rx_char,
    output logic       rx_char_valid,
    output logic       rx_char_is_flow
);
    int         taken   = 0;
    logic [7:0] last_q  = 8'h00;
    logic       stall_q = 1'b0;
    initial begin
        rx_char = 8'h00;
        rx_char_valid = 1'b0;
        rx_char_is_flow = 1'b0;
    end
    // Ready on alternate cycles only, so the FIFO meets a slow far end
    always @(negedge sys_clk) stall_q <= !stall_q;
    assign tx_char_ready = drain_en && stall_q;
    always @(posedge sys_clk) begin
        if (tx_char_valid && tx_char_ready) begin
            taken <= taken + 1;
            last_q <= tx_char;
        end
    end
    task automatic send(input logic [7:0] c);
        @(negedge sys_clk);
        rx_char = c;
        rx_char_valid = 1'b1;
        @(negedge sys_clk);
        rx_char_valid = 1'b0;
        rx_char = ~c;
    endtask : send
endmodule : ufmc_line_model

// *** sim/tb_ufmc_core.sv ***
`timescale 1ns/1ps
module tb_ufmc_core
    import ufmc_pkg::*;
();
    logic          sys_clk = 1'b0, arst_n = 1'b0, enh = 1'b0, cts_n_pin = 1'b0, drain_en = 1'b0;
    ufmc_host_type host = '0;
    logic [7:0]    rdata, tx_in_data = 8'h00, tx_char, rx_char, div_low, divisor_high, divisor_fraction;
    logic [7:0]    rx_out_data;
    logic          tx_in_ready, tx_char_valid, tx_char_ready, rx_char_valid, rx_char_is_flow;
    logic          tx_line_low, dtr_n, rts_n, int_oe, wake_int_en, tx_int, rx_int;
    int            miscompares = 0, num_checks = 0, n;
    logic [7:0]    vals [4];
    always #25 sys_clk = ~sys_clk;
    ufmc_core dut_u (.sys_clk(sys_clk), .arst_n(arst_n), .host(host), .rdata(rdata),
        .enhanced_feature_register_en(enh), .int_req(1'b1), .int_out(), .int_oe(int_oe),
        .tx_in_data(tx_in_data), .tx_in_ready(tx_in_ready), .tx_char(tx_char), .tx_char_valid(tx_char_valid),
        .tx_char_ready(tx_char_ready), .rx_char(rx_char), .rx_char_valid(rx_char_valid),
        .rx_char_is_flow(rx_char_is_flow), .rx_out_data(rx_out_data), .rx_out_valid(), .rx_out_ready(1'b0), .fmt(),
        .par_value(), .par_forced(), .half_stop(), .tx_line_low(tx_line_low), .dtr_n(dtr_n), .rts_n(rts_n),
        .cts_n_pin(cts_n_pin), .ring_indicator_in_n(1'b1), .ring_in_looped_n(), .user_output_one_n(),
        .user_output_two_n(), .loopback(), .tx_resume(), .wake_int_en(wake_int_en), .tx_int(tx_int),
        .rx_int(rx_int), .div_low(div_low), .divisor_high(divisor_high), .divisor_fraction(divisor_fraction));
    ufmc_line_model line_u (.sys_clk(sys_clk), .drain_en(drain_en), .tx_char(tx_char),
        .tx_char_valid(tx_char_valid), .tx_char_ready(tx_char_ready), .rx_char(rx_char),
        .rx_char_valid(rx_char_valid), .rx_char_is_flow(rx_char_is_flow));
    task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(negedge sys_clk);
        host = '{1'b1, 1'b0, a, d};
        tx_in_data = d;
        @(negedge sys_clk);
        host = '0;
    endtask : wr
    // Data is read at the low phase, before the edge that may clear status
    task automatic rd(input logic [2:0] a, input logic [7:0] m, input logic [7:0] e, input string nm);
        @(negedge sys_clk);
        host = '{1'b0, 1'b1, a, 8'h00};
        #1 chk(nm, rdata & m, e);
        @(negedge sys_clk);
        host = '0;
    endtask : rd
    task automatic fill(input int k);
        for (int i = 0; i < k; i++) wr(UFMC_ADDR_DATA, 8'(i));
        @(negedge sys_clk);
    endtask : fill
    task automatic test_done();
        $display("checks %0d miscompares %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : test_done
    initial begin
        repeat (5000) @(posedge sys_clk);
        miscompares++;
        test_done();
    end
    initial begin
        repeat (5) @(negedge sys_clk);
        arst_n = 1'b1;
        rd(UFMC_ADDR_LINE, 8'hFF, UFMC_LINE_RST, "line rst");
        rd(UFMC_ADDR_MODEM, 8'hFF, UFMC_MODEM_RST, "modem rst");
        rd(UFMC_ADDR_STATUS, 8'hC0, 8'h00, "fifo off");
        chk("dtr rts rst", {dtr_n, rts_n}, 8'h03);
        wr(UFMC_ADDR_STATUS, 8'h09);
        chk("wake plain", wake_int_en, 8'h00);
        rd(UFMC_ADDR_STATUS, 8'hC0, 8'hC0, "fifo on");
        vals = '{8'h03, 8'h1C, 8'h6A, 8'h3D};
        foreach (vals[i]) begin
            wr(UFMC_ADDR_LINE, vals[i]);
            chk("break", tx_line_low, vals[i][6]);
            rd(UFMC_ADDR_LINE, 8'hFF, vals[i], "line");
        end
        // Without enhanced mode the any-character bit must not stick
        vals = '{8'h01, 8'h02, 8'h08, 8'h3F};
        foreach (vals[i]) begin
            wr(UFMC_ADDR_MODEM, vals[i]);
            chk("dtr", dtr_n, !vals[i][0] || vals[i][4]);
            chk("int oe", int_oe, vals[i][3] && !vals[i][4]);
            rd(UFMC_ADDR_MODEM, 8'hFF, vals[i] & 8'h1F, "modem");
        end
        wr(UFMC_ADDR_MODEM, 8'h00);
        wr(UFMC_ADDR_LINE, 8'h80);
        wr(UFMC_ADDR_DATA, 8'h5A);
        wr(UFMC_ADDR_DIVHI, 8'h3C);
        wr(UFMC_ADDR_DIVFR, 8'h07);
        chk("divisors", div_low ^ divisor_high ^ divisor_fraction, 8'h5A ^ 8'h3C ^ 8'h07);
        rd(UFMC_ADDR_DATA, 8'hFF, 8'h5A, "div low");
        wr(UFMC_ADDR_LINE, 8'h00);
        for (n = 0; n < 40 && tx_in_ready === 1'b1; n++) wr(UFMC_ADDR_DATA, 8'(n));
        chk("fill depth", 8'(n), 8'(UFMC_FIFO_D));
        wr(UFMC_ADDR_STATUS, 8'h05);
        @(negedge sys_clk);
        chk("tx flushed", {tx_char_valid, tx_in_ready}, 8'h01);
        fill(3);
        wr(UFMC_ADDR_STATUS, 8'h04);
        @(negedge sys_clk);
        chk("no flush", tx_char_valid, 8'h01);
        rd(UFMC_ADDR_STATUS, 8'hC0, 8'h00, "fifo off");
        drain_en = 1'b1;
        for (n = 0; n < 40 && line_u.taken < 3; n++) @(negedge sys_clk);
        chk("drained", 8'(line_u.taken), 8'h03);
        chk("last out", line_u.last_q, 8'h02);
        drain_en = 1'b0;
        wr(UFMC_ADDR_STATUS, 8'h47);
        for (int i = 0; i < 3; i++) line_u.send(8'hA0 + 8'(i));
        @(negedge sys_clk);
        chk("rx below 4", rx_int, 8'h00);
        line_u.send(8'hA3);
        @(negedge sys_clk);
        chk("rx at 4", rx_int, 8'h01);
        chk("rx head", rx_out_data, 8'hA0);
        enh = 1'b1;
        wr(UFMC_ADDR_STATUS, 8'h21);
        @(negedge sys_clk);
        chk("shared 8", rx_int, 8'h00);
        fill(3);
        chk("tx below 8", tx_int, 8'h01);
        fill(7);
        chk("tx at 10", tx_int, 8'h00);
        wr(UFMC_ADDR_STATUS, 8'h09);
        chk("wake", wake_int_en, 8'h01);
        cts_n_pin = 1'b1;
        wr(UFMC_ADDR_MODEM, 8'h02);
        wr(UFMC_ADDR_MODEM, 8'h00);
        rd(UFMC_ADDR_STATUS, 8'h20, 8'h20, "flow rise");
        rd(UFMC_ADDR_STATUS, 8'h20, 8'h00, "flow clear");
        wr(UFMC_ADDR_MODEM, 8'h22);
        wr(UFMC_ADDR_MODEM, 8'h20);
        rd(UFMC_ADDR_STATUS, 8'h20, 8'h20, "rts rise");
        rd(UFMC_ADDR_MODEM, 8'hFF, 8'h20, "any char");
        line_u.send(8'h11);
        test_done();
    end
endmodule : tb_ufmc_core
bind ufmc_core ufmc_chk chk_u (.sys_clk(sys_clk), .arst_n(arst_n), .host(host),
    .enhanced_feature_register_en(enhanced_feature_register_en), .rx_char_valid(rx_char_valid),
    .ring_indicator_in_n(ring_indicator_in_n), .fmt(fmt), .par_value(par_value), .par_forced(par_forced),
    .half_stop(half_stop), .tx_line_low(tx_line_low), .dtr_n(dtr_n), .rts_n(rts_n),
    .ring_in_looped_n(ring_in_looped_n), .user_output_one_n(user_output_one_n),
    .user_output_two_n(user_output_two_n), .loopback(loopback), .tx_resume(tx_resume));
